// file: core/pdsc_pkg.sv
package pdsc_pkg;
    localparam logic [7:0]  SBC_RESET      = 8'h1F;
    localparam int          SBC_SEL_BIT    = 7;
    localparam int          SBC_FLOAT_BIT  = 6;
    localparam logic [7:0]  SBC_ONES_MASK  = 8'h1F;
    localparam logic [11:0] ADDR_CONTROL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam logic [11:0] ADDR_IRQ_FLAG  = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK  = 12'h00C;
    localparam logic [3:0]  IRQ_RESET      = 4'h0;
    localparam int          EV_SLEEP_IN    = 0;
    localparam int          EV_STANDBY_IN  = 1;
    localparam int          EV_WAKE        = 2;
    localparam int          EV_RESET_EXIT  = 3;

    typedef enum logic [1:0] {
        PDSC_RUN     = 2'b00,
        PDSC_SLEEP   = 2'b01,
        PDSC_STANDBY = 2'b11,
        PDSC_WARMUP  = 2'b10
    } pdsc_mode_t;

    typedef enum logic [1:0] {
        PDSC_WAKE_NONE = 2'b00,
        PDSC_WAKE_IRQ  = 2'b01,
        PDSC_WAKE_DMA  = 2'b10,
        PDSC_WAKE_NMI  = 2'b11
    } pdsc_wake_t;
endpackage

// file: core/pdsc_ctrl.sv
// Notes on behaviour
// - Standby control register is 8 bits, read/write, resets to 0x1F.
// - Bit 7 picks halt effect: 0 sleep, 1 standby.
// - Setting bit 7 is refused while watchdog run enable is set.
// - Bit 6 set floats all I/O ports on standby entry; clear holds them.
// - Setting bit 6 is refused while watchdog run enable is set.
// - Bit 5 reads 0; bits 4..0 ignore writes and read 1.
// - Halt with bit 7 clear stops CPU only; clock, peripherals run.
// - Acceptable interrupt ends sleep; masked or disabled ones do not.
// - DMA address error during sleep ends sleep and starts its exception.
// - Reset pin low with NMI high during sleep gives power-on reset.
// - Reset pin low with NMI low in power-down gives manual reset.
// - Selected NMI edge during sleep raises NMI and ends sleep.
// - Halt with bit 7 set stops CPU, clock, peripherals; keeps state.
// - Standby entry clears watchdog bits 7..5 and reset ctrl/status.
// - Standby entry clears DMA, timer unit and serial unit registers.
// - Other controllers and this register keep contents in standby.
// - NMI edge in standby restarts clock for watchdog, then whole chip.
// - Reset pin low with NMI high in standby gives power-on reset.
`timescale 1ns/10ps
module pdsc_ctrl (
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ,
    input  wire logic        HALT_REQ,
    input  wire logic        IRQ_PENDING,
    input  wire logic [3:0]  IRQ_LEVEL,
    input  wire logic [3:0]  CPU_MASK_LEVEL,
    input  wire logic        DMA_ADDR_ERR,
    input  wire logic        WDT_RUN_ENABLE,
    input  wire logic        WDT_OVERFLOW,
    input  wire logic        NMI_EDGE_SELECT,
    input  wire logic        RESET_PIN_N,
    input  wire logic        NMI_PIN,
    output logic             CPU_HALT,
    output logic             CLOCK_STOP,
    output logic             WDT_CLOCK_ONLY,
    output logic             PORT_FLOAT,
    output logic             WDT_STANDBY_INIT,
    output logic             PERIPH_STANDBY_INIT,
    output logic             WAKE_IRQ,
    output logic             WAKE_DMA_ERR,
    output logic             WAKE_NMI,
    output logic             POWER_ON_RESET,
    output logic             MANUAL_RESET
);
    import pdsc_pkg::*;

    typedef struct packed {
        logic [7:0]  ctl;
        logic [3:0]  flag;
        logic [3:0]  mask;
        pdsc_mode_t  mode;
        logic [1:0]  rst_sync;
        logic [1:0]  nmi_sync;
        logic        nmi_prev;
        logic        rst_prev;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        cpu_halt;
        logic        clk_stop;
        logic        wdt_only;
        logic        port_float;
        logic        wdt_init;
        logic        per_init;
        logic        wake_irq;
        logic        wake_dma;
        logic        wake_nmi;
        logic        por;
        logic        mrst;
    } pdsc_state_t;

    pdsc_state_t st_reg;
    pdsc_state_t st_next;

    logic        wr_acc;
    logic        rd_acc;
    logic        mapped;
    logic        nmi_now;
    logic        rst_now;
    logic        nmi_edge;
    logic        rst_fall;
    logic        irq_ok;
    logic [3:0]  ev;
    logic [31:0] rd_val;

    always_comb begin
        st_next = st_reg;
        ev      = 4'h0;
        // Only the second stage is read by anything
        st_next.rst_sync = {st_reg.rst_sync[0], RESET_PIN_N};
        st_next.nmi_sync = {st_reg.nmi_sync[0], NMI_PIN};
        rst_now  = st_reg.rst_sync[1];
        nmi_now  = st_reg.nmi_sync[1];
        st_next.rst_prev = rst_now;
        st_next.nmi_prev = nmi_now;
        rst_fall = st_reg.rst_prev && !rst_now;
        // Rising edge when select is 1, falling when 0
        nmi_edge = NMI_EDGE_SELECT ? (!st_reg.nmi_prev && nmi_now)
                                   : (st_reg.nmi_prev && !nmi_now);
        irq_ok = IRQ_PENDING && (IRQ_LEVEL > CPU_MASK_LEVEL);

        mapped = (PADDR == ADDR_CONTROL) || (PADDR == ADDR_STATUS) ||
                 (PADDR == ADDR_IRQ_FLAG) || (PADDR == ADDR_IRQ_MASK);
        wr_acc = PSEL && PENABLE && PWRITE && !st_reg.pready;
        rd_acc = PSEL && PENABLE && !PWRITE && !st_reg.pready;
        case (PADDR)
            ADDR_CONTROL:  rd_val = {24'h00_0000, st_reg.ctl};
            ADDR_STATUS:   rd_val = {28'h000_0000, 2'b00, st_reg.mode};
            ADDR_IRQ_FLAG: rd_val = {28'h000_0000, st_reg.flag};
            ADDR_IRQ_MASK: rd_val = {28'h000_0000, st_reg.mask};
            default:       rd_val = 32'h0000_0000;
        endcase

        st_next.pready  = PSEL && PENABLE && !st_reg.pready;
        st_next.pslverr = PSEL && PENABLE && !st_reg.pready && !mapped;
        if (rd_acc) begin
            st_next.prdata = rd_val;
        end

        // Pulses drop back after one cycle
        st_next.wdt_init = 1'b0;
        st_next.per_init = 1'b0;
        st_next.wake_irq = 1'b0;
        st_next.wake_dma = 1'b0;
        st_next.wake_nmi = 1'b0;
        st_next.por      = 1'b0;
        st_next.mrst     = 1'b0;

        if (wr_acc && PADDR == ADDR_CONTROL) begin
            // Register is held as-is through standby
            if (!PWDATA[SBC_SEL_BIT] || !WDT_RUN_ENABLE) begin
                st_next.ctl[SBC_SEL_BIT] = PWDATA[SBC_SEL_BIT];
            end
            if (!PWDATA[SBC_FLOAT_BIT] || !WDT_RUN_ENABLE) begin
                st_next.ctl[SBC_FLOAT_BIT] = PWDATA[SBC_FLOAT_BIT];
            end
        end
        st_next.ctl[5:0] = SBC_ONES_MASK[5:0];
        if (wr_acc && PADDR == ADDR_IRQ_MASK) begin
            st_next.mask = PWDATA[3:0];
        end

        case (st_reg.mode)
            PDSC_RUN: begin
                if (HALT_REQ && st_reg.ctl[SBC_SEL_BIT]) begin
                    st_next.mode     = PDSC_STANDBY;
                    st_next.cpu_halt = 1'b1;
                    st_next.clk_stop = 1'b1;
                    st_next.port_float = st_reg.ctl[SBC_FLOAT_BIT];
                    st_next.wdt_init = 1'b1;
                    st_next.per_init = 1'b1;
                    ev[EV_STANDBY_IN] = 1'b1;
                end else if (HALT_REQ) begin
                    // Clock and peripherals stay up in sleep
                    st_next.mode     = PDSC_SLEEP;
                    st_next.cpu_halt = 1'b1;
                    ev[EV_SLEEP_IN] = 1'b1;
                end
            end
            PDSC_SLEEP: begin
                if (rst_fall) begin
                    st_next.por  = nmi_now;
                    st_next.mrst = !nmi_now;
                    st_next.mode = PDSC_RUN;
                    st_next.cpu_halt = 1'b0;
                    ev[EV_RESET_EXIT] = 1'b1;
                end else if (nmi_edge) begin
                    st_next.wake_nmi = 1'b1;
                    st_next.mode = PDSC_RUN;
                    st_next.cpu_halt = 1'b0;
                    ev[EV_WAKE] = 1'b1;
                end else if (DMA_ADDR_ERR) begin
                    st_next.wake_dma = 1'b1;
                    st_next.mode = PDSC_RUN;
                    st_next.cpu_halt = 1'b0;
                    ev[EV_WAKE] = 1'b1;
                end else if (irq_ok) begin
                    st_next.wake_irq = 1'b1;
                    st_next.mode = PDSC_RUN;
                    st_next.cpu_halt = 1'b0;
                    ev[EV_WAKE] = 1'b1;
                end
            end
            PDSC_STANDBY, PDSC_WARMUP: begin
                // Reset pin wins over a pending warm-up
                if (rst_fall) begin
                    st_next.por  = nmi_now;
                    st_next.mrst = !nmi_now;
                    st_next.mode = PDSC_RUN;
                    st_next.cpu_halt = 1'b0;
                    st_next.clk_stop = 1'b0;
                    st_next.wdt_only = 1'b0;
                    st_next.port_float = 1'b0;
                    ev[EV_RESET_EXIT] = 1'b1;
                end else if (st_reg.mode == PDSC_STANDBY && nmi_edge) begin
                    st_next.mode     = PDSC_WARMUP;
                    st_next.wdt_only = 1'b1;
                end else if (st_reg.mode == PDSC_WARMUP && WDT_OVERFLOW) begin
                    // Clock deemed stable only after watchdog overflow
                    st_next.mode     = PDSC_RUN;
                    st_next.wdt_only = 1'b0;
                    st_next.clk_stop = 1'b0;
                    st_next.cpu_halt = 1'b0;
                    st_next.port_float = 1'b0;
                    st_next.wake_nmi = 1'b1;
                    ev[EV_WAKE] = 1'b1;
                end
            end
            default: begin
                st_next.mode = PDSC_RUN;
            end
        endcase

        // Set beats write-one-to-clear
        if (wr_acc && PADDR == ADDR_IRQ_FLAG) begin
            st_next.flag = st_reg.flag & ~PWDATA[3:0];
        end
        st_next.flag = st_next.flag | ev;
        st_next.irq  = |(st_next.flag & st_next.mask);
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            st_reg          <= '0;
            st_reg.ctl      <= SBC_RESET;
            st_reg.mode     <= PDSC_RUN;
            st_reg.flag     <= IRQ_RESET;
            st_reg.mask     <= IRQ_RESET;
            st_reg.rst_sync <= 2'b11;
            st_reg.rst_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign PRDATA              = st_reg.prdata;
    assign PREADY              = st_reg.pready;
    assign PSLVERR             = st_reg.pslverr;
    assign IRQ                 = st_reg.irq;
    assign CPU_HALT            = st_reg.cpu_halt;
    assign CLOCK_STOP          = st_reg.clk_stop;
    assign WDT_CLOCK_ONLY      = st_reg.wdt_only;
    assign PORT_FLOAT          = st_reg.port_float;
    assign WDT_STANDBY_INIT    = st_reg.wdt_init;
    assign PERIPH_STANDBY_INIT = st_reg.per_init;
    assign WAKE_IRQ            = st_reg.wake_irq;
    assign WAKE_DMA_ERR        = st_reg.wake_dma;
    assign WAKE_NMI            = st_reg.wake_nmi;
    assign POWER_ON_RESET      = st_reg.por;
    assign MANUAL_RESET        = st_reg.mrst;

    chk_ctl_fixed_bits: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        st_reg.ctl[5:0] == SBC_ONES_MASK[5:0])
        else $error("reserved bits wrong");
    chk_sel_locked: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (wr_acc && PADDR == ADDR_CONTROL && WDT_RUN_ENABLE
         && !st_reg.ctl[7]) |=> !st_reg.ctl[7])
        else $error("select set while watchdog runs");
    chk_float_locked: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (wr_acc && PADDR == ADDR_CONTROL && WDT_RUN_ENABLE
         && !st_reg.ctl[6]) |=> !st_reg.ctl[6])
        else $error("float set while watchdog runs");
    chk_ctl_write: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (wr_acc && PADDR == ADDR_CONTROL && !WDT_RUN_ENABLE)
        |=> st_reg.ctl[7:6] == $past(PWDATA[7:6]))
        else $error("control write lost");
    chk_ready_answer: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (PSEL && PENABLE && !PREADY) |=> PREADY)
        else $error("ready not given");
    chk_ready_pulse: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        PREADY |=> !PREADY)
        else $error("ready held too long");
    chk_err_unmapped: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (PSEL && PENABLE && !PREADY && !mapped)
        |=> PREADY && PSLVERR)
        else $error("unmapped access not refused");
    chk_irq_level: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        IRQ == |(st_reg.flag & st_reg.mask))
        else $error("interrupt level wrong");
    chk_flag_sticky: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        !(wr_acc && PADDR == ADDR_IRQ_FLAG)
        |=> (st_reg.flag & $past(st_reg.flag)) == $past(st_reg.flag))
        else $error("status bit dropped");
    chk_halt_sleep: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode == PDSC_RUN && HALT_REQ && !st_reg.ctl[7])
        |=> CPU_HALT && !CLOCK_STOP)
        else $error("sleep entry wrong");
    chk_sleep_clock: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        st_reg.mode == PDSC_SLEEP
        |-> CPU_HALT && !CLOCK_STOP && !WDT_CLOCK_ONLY)
        else $error("sleep stopped the clock");
    chk_halt_standby: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode == PDSC_RUN && HALT_REQ && st_reg.ctl[7])
        |=> CLOCK_STOP && WDT_STANDBY_INIT && PERIPH_STANDBY_INIT
            && PORT_FLOAT == $past(st_reg.ctl[6]))
        else $error("standby entry wrong");
    chk_standby_stop: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        st_reg.mode == PDSC_STANDBY
        |-> CPU_HALT && CLOCK_STOP && !WDT_CLOCK_ONLY)
        else $error("standby outputs wrong");
    chk_standby_stays: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode == PDSC_STANDBY && !nmi_edge && !rst_fall)
        |=> st_reg.mode == PDSC_STANDBY)
        else $error("standby left without cause");
    chk_init_pulse: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        WDT_STANDBY_INIT |-> PERIPH_STANDBY_INIT
            && st_reg.mode == PDSC_STANDBY ##1 !WDT_STANDBY_INIT)
        else $error("standby init pulse wrong");
    chk_ctl_kept: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode != PDSC_RUN && !(wr_acc && PADDR == ADDR_CONTROL))
        |=> st_reg.ctl == $past(st_reg.ctl))
        else $error("control lost in power-down");
    chk_wake_irq: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode == PDSC_SLEEP && irq_ok && !DMA_ADDR_ERR
         && !rst_fall && !nmi_edge) |=> WAKE_IRQ && !CPU_HALT)
        else $error("interrupt did not wake");
    chk_masked_irq: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode == PDSC_SLEEP && IRQ_LEVEL <= CPU_MASK_LEVEL
         && !DMA_ADDR_ERR && !rst_fall && !nmi_edge) |=> !WAKE_IRQ)
        else $error("masked interrupt woke cpu");
    chk_dma_wake: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode == PDSC_SLEEP && DMA_ADDR_ERR && !rst_fall
         && !nmi_edge) |=> WAKE_DMA_ERR && !CPU_HALT)
        else $error("dma error did not wake");
    chk_nmi_sleep: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode == PDSC_SLEEP && nmi_edge && !rst_fall)
        |=> WAKE_NMI && !CPU_HALT)
        else $error("nmi did not end sleep");
    chk_reset_kind: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode != PDSC_RUN && rst_fall)
        |=> (POWER_ON_RESET == $past(nmi_now))
            && (MANUAL_RESET != POWER_ON_RESET))
        else $error("reset kind wrong");
    chk_manual_reset: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode != PDSC_RUN && rst_fall && !nmi_now)
        |=> MANUAL_RESET && !POWER_ON_RESET && !CPU_HALT)
        else $error("manual reset not given");
    chk_standby_por: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode[1] && rst_fall && nmi_now) |=> POWER_ON_RESET
            && !CLOCK_STOP && !PORT_FLOAT && !WDT_CLOCK_ONLY)
        else $error("standby power-on reset wrong");
    chk_warmup_entry: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode == PDSC_STANDBY && nmi_edge && !rst_fall)
        |=> WDT_CLOCK_ONLY && CLOCK_STOP && CPU_HALT)
        else $error("warm-up entry wrong");
    chk_warmup_exit: assert property (
        @(posedge CLOCK) disable iff (!RSTN)
        (st_reg.mode == PDSC_WARMUP && WDT_OVERFLOW && !rst_fall)
        |=> WAKE_NMI && !CLOCK_STOP ##1 !WAKE_NMI)
        else $error("warm-up exit wrong");
endmodule

// file: test/pdsc_cpu_model.sv
`timescale 1ns/10ps
module pdsc_cpu_model #(
    parameter int OVF_DELAY = 20
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic halt_toggle,
    input  wire logic wdt_clock_only,
    output logic      halt_req,
    output logic      wdt_overflow
);
    logic     toggle_q;
    int       warm_cnt;

    // One-cycle halt request pulse per toggle of the bench request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            toggle_q     <= 1'b0;
            halt_req     <= 1'b0;
            warm_cnt     <= 0;
            wdt_overflow <= 1'b0;
        end else begin
            toggle_q     <= halt_toggle;
            halt_req     <= halt_toggle ^ toggle_q;
            // Overflow only after a full count on the lone watchdog clock
            warm_cnt     <= wdt_clock_only ? warm_cnt + 1 : 0;
            wdt_overflow <= wdt_clock_only && (warm_cnt == OVF_DELAY);
        end
    end
endmodule

// file: test/power_down_sleep_standby_ctrl_bench.sv
`timescale 1ns/10ps
module power_down_sleep_standby_ctrl_bench;
    import pdsc_pkg::*;
    logic        clock, rstn, psel, penable, pwrite, halt_go, irq_pending;
    logic        dma_err, wdt_run, wdt_ovf, nmi_sel, rst_pin_n, nmi_pin;
    logic        halt_req, cpu_halt, clk_stop, wdt_only, port_float;
    logic        wdt_init, per_init, w_irq, w_dma, w_nmi, por, mrst;
    logic        pready, pslverr, irq, halt_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  irq_level, mask_level;
    logic [9:0]  ev;
    logic [32:0] rd_q[$];
    logic [9:0]  ev_q[$];
    int          failures, num_checks;

    pdsc_ctrl DUT (.CLOCK(clock), .RSTN(rstn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
        .HALT_REQ(halt_req), .IRQ_PENDING(irq_pending),
        .IRQ_LEVEL(irq_level), .CPU_MASK_LEVEL(mask_level),
        .DMA_ADDR_ERR(dma_err), .WDT_RUN_ENABLE(wdt_run),
        .WDT_OVERFLOW(wdt_ovf), .NMI_EDGE_SELECT(nmi_sel),
        .RESET_PIN_N(rst_pin_n), .NMI_PIN(nmi_pin), .CPU_HALT(cpu_halt),
        .CLOCK_STOP(clk_stop), .WDT_CLOCK_ONLY(wdt_only),
        .PORT_FLOAT(port_float), .WDT_STANDBY_INIT(wdt_init),
        .PERIPH_STANDBY_INIT(per_init), .WAKE_IRQ(w_irq),
        .WAKE_DMA_ERR(w_dma), .WAKE_NMI(w_nmi), .POWER_ON_RESET(por),
        .MANUAL_RESET(mrst));
    pdsc_cpu_model model (.clock(clock), .rst_n(rstn), .halt_toggle(halt_go),
        .wdt_clock_only(wdt_only), .halt_req(halt_req),
        .wdt_overflow(wdt_ovf));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic finish_test();
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // Settled outputs are watched on the falling edge, away from races
    always @(negedge clock) begin
        if (pready === 1'b1) begin
            if (rd_q.size() == 0)
                chk(33'h1_0000_0000, 33'h0_0000_0000);
            else begin
                chk({pslverr, pwrite ? 32'h0 : prdata}, rd_q[0]);
                rd_q.delete(0);
            end
        end
        ev = {cpu_halt & ~halt_q, cpu_halt & ~halt_q & clk_stop,
              cpu_halt & ~halt_q & port_float, wdt_init, per_init, w_irq,
              w_dma, w_nmi, por, mrst};
        halt_q = cpu_halt;
        if (ev !== 10'h000) begin
            if (ev_q.size() == 0)
                chk(ev, 10'h000);
            else
                chk(ev, ev_q.pop_front());
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic err,
                       input logic [31:0] exp);
        rd_q.push_back({err, wr ? 32'h0 : exp});
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Slave latency is not assumed; the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle();
        int n;
        n = 0;
        while ((rd_q.size() != 0 || ev_q.size() != 0) && n < 200) begin
            @(posedge clock);
            n++;
        end
        chk(33'(rd_q.size() + ev_q.size()), 33'h0_0000_0000);
        repeat (4) @(posedge clock);
    endtask

    task automatic halt(input logic [9:0] e);
        ev_q.push_back(e);
        @(posedge clock);
        halt_go <= ~halt_go;
        settle();
    endtask

    task automatic pin_reset(input logic [9:0] e);
        ev_q.push_back(e);
        rst_pin_n <= 1'b0;
        settle();
        rst_pin_n <= 1'b1;
        repeat (6) @(posedge clock);
    endtask

    initial begin
        #200000;
        failures++;
        finish_test();
    end

    initial begin
        {psel, penable, pwrite, halt_go, irq_pending, dma_err} = 6'h00;
        {wdt_run, nmi_sel, nmi_pin} = 3'h0;
        {paddr, pwdata, irq_level, mask_level} = '0;
        rst_pin_n = 1'b1;
        failures = 0;
        num_checks = 0;
        r = $urandom(32'h5016_3e89);
        rstn = 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        apb(0, ADDR_CONTROL, 0, 0, 32'h0000_001F);
        apb(0, ADDR_STATUS, 0, 0, 32'h0000_0000);
        wdt_run <= 1'b1;
        r = ($urandom | 32'h0000_00C0) & ~32'h0000_0020;
        apb(1, ADDR_CONTROL, r, 0, 0);
        apb(0, ADDR_CONTROL, 0, 0, 32'h0000_001F);
        wdt_run <= 1'b0;
        apb(1, ADDR_CONTROL, 32'h0000_0040, 0, 0);
        apb(0, ADDR_CONTROL, 0, 0, 32'h0000_005F);
        apb(1, ADDR_CONTROL, 32'h0000_0080, 0, 0);
        apb(0, ADDR_CONTROL, 0, 0, 32'h0000_009F);
        apb(1, ADDR_CONTROL, 32'h0000_0000, 0, 0);
        apb(0, 12'h010, 0, 1, 32'h0000_0000);
        apb(1, 12'h014, 32'h0000_FFFF, 1, 0);
        halt(10'h200);
        apb(0, ADDR_STATUS, 0, 0, 32'h0000_0001);
        // Level equal to the mask must not wake
        irq_level <= 4'h3;
        mask_level <= 4'h3;
        irq_pending <= 1'b1;
        repeat (12) @(posedge clock);
        chk(cpu_halt, 1'b1);
        ev_q.push_back(10'h010);
        irq_level <= 4'h4;
        settle();
        irq_pending <= 1'b0;
        halt(10'h200);
        ev_q.push_back(10'h008);
        dma_err <= 1'b1;
        @(posedge clock);
        dma_err <= 1'b0;
        settle();
        nmi_sel <= 1'b1;
        halt(10'h200);
        ev_q.push_back(10'h004);
        nmi_pin <= 1'b1;
        settle();
        halt(10'h200);
        pin_reset(10'h002);
        nmi_pin <= 1'b0;
        repeat (6) @(posedge clock);
        halt(10'h200);
        pin_reset(10'h001);
        apb(1, ADDR_CONTROL, 32'h0000_00C0, 0, 0);
        halt(10'h3E0);
        apb(0, ADDR_CONTROL, 0, 0, 32'h0000_00DF);
        ev_q.push_back(10'h004);
        nmi_pin <= 1'b1;
        repeat (6) @(posedge clock);
        chk({wdt_only, clk_stop, cpu_halt}, 3'h7);
        settle();
        apb(1, ADDR_CONTROL, 32'h0000_0080, 0, 0);
        halt(10'h360);
        pin_reset(10'h002);
        apb(0, ADDR_IRQ_FLAG, 0, 0, 32'h0000_000F);
        chk(irq, 1'b0);
        apb(1, ADDR_IRQ_MASK, 32'h0000_000F, 0, 0);
        repeat (3) @(posedge clock);
        chk(irq, 1'b1);
        apb(1, ADDR_IRQ_FLAG, 32'h0000_000F, 0, 0);
        repeat (3) @(posedge clock);
        chk(irq, 1'b0);
        apb(0, ADDR_IRQ_FLAG, 0, 0, 32'h0000_0000);
        settle();
        finish_test();
    end
endmodule
